// *** spi_status_and_data_buffers_consts.svh ***
/*
  offsets, field positions, reset values and counts for the spi status
  and data buffer block; assumes inclusion by bare name
*/
`ifndef SPI_STATUS_AND_DATA_BUFFERS_CONSTS_SVH
`define SPI_STATUS_AND_DATA_BUFFERS_CONSTS_SVH
// ----------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------
`define IDX_STATUS   22'h088383
`define IDX_DATA     22'h088384
`define IDX_SEQ_LEN  22'h088388
// ----------------------------------------
// status fields
// ----------------------------------------
`define ST_OVR       0
`define ST_IDLE      1
`define ST_MODE_FAULT_FLAG      2
`define ST_PARITY_ERROR_FLAG      3
`define ST_RSVD_HI   4'hA
// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define SEQ_LEN_RST  3'h0
`define CMD_PTR_HOME 3'h0
`define FULL_WIDTH   6'h20
`endif

// *** spi_status_and_data_buffers_pkg.sv ***
/*
  types shared by the spi status and data buffer block;
  assumes nothing of its surroundings
*/
package spi_status_and_data_buffers_pkg;
  typedef logic [1:0] stage_idx_t;
  typedef enum logic {
    rd_from_rx,
    rd_from_tx
  } read_source_t;
endpackage

// *** spi_status_and_data_buffers.sv ***
/*
  status flags, four-stage transmit and receive buffers and the
  sequence-length register of an spi controller, on an apb slave.
  assumes the shift engine, control register bits and serial pins
  arrive as ports; pins pass a two-flop synchroniser here.
*/
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "spi_status_and_data_buffers_consts.svh"

// Overview of operation
// - overrun when frame ends into full rx
// - read flag at 1, write 0 clears
// - master idle flag from enable, tx buffer, sequencer
// - slave idle flag follows function enable
// - master fault on slave select going active
// - slave fault on early slave select release
// - polarity bit defines slave select active level
// - parity error on bad full-duplex frame
// - b4,b6 read 0; b5,b7 read 1
// - four tx, four rx stages, one address
// - data right-justified both directions
// - unused rx upper bits copied from tx
// - overrun leaves receive buffer untouched
// - writes go to tx pointer, wrap by count
// - enable 0 to 1 homes tx pointer
// - writes ignored after frame count reached
// - read source select, rx read pointer advances
// - enable rewritten 1 homes rx pointer
// - tx reads give last write, zero when locked
// - sequence length picks command order, slave 0
// - transmit-only does no reception
// - error flags raise interrupt when enabled
module spi_status_and_data_buffers #(
  parameter int STAGES = 4
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [23:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_function_enable,
  input  wire logic        i_enable_write,
  input  wire logic        i_enable_wdata,
  input  wire logic        i_master_select,
  input  wire logic        i_transmit_only_select,
  input  wire logic        i_mode_fault_detect_enable,
  input  wire logic        i_parity_enable,
  input  wire logic        i_error_interrupt_enable,
  input  wire logic        i_slave_select_polarity,
  input  wire logic [1:0]  i_frame_count,
  input  wire logic        i_read_source_select,
  input  wire logic        i_longword_access_select,
  input  wire logic        i_serial_clock_line,
  input  wire logic        i_slave_select_pin,
  input  wire logic        i_xfer_done,
  input  wire logic [31:0] i_rx_shift_data,
  input  wire logic        i_parity_bad,
  input  wire logic [5:0]  i_data_bits,
  input  wire logic [1:0]  i_tx_stage_sel,
  input  wire logic        i_tx_empty_event,
  input  wire logic        i_seq_idle,
  input  wire logic [2:0]  i_command_pointer,
  output logic      [31:0] o_tx_stage_data,
  output logic             o_tx_has_data,
  output logic             o_rx_full_event,
  output logic      [2:0]  o_sequence_length,
  output logic      [2:0]  o_command_select,
  output logic             o_error_irq,
  output logic             o_transfer_active_flag
);

  // pointers are two bits wide, so only four stages can be addressed
  if (STAGES != 4) begin : g_bad_stages
    $error("only four stages are supported");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] sclk_q;
  logic [2:0] ss_q;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sclk_q <= 3'h0;
      ss_q   <= 3'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], i_serial_clock_line};
      ss_q   <= {ss_q[1:0], i_slave_select_pin};
    end
  end
  wire ss_act      = ss_q[1] == i_slave_select_polarity;
  wire ss_act_prev = ss_q[2] == i_slave_select_polarity;
  wire ss_rise     = ss_act & ~ss_act_prev;
  wire ss_fall     = ~ss_act & ss_act_prev;
  wire sclk_rise   = sclk_q[1] & ~sclk_q[2];

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire acc      = psel & penable;
  wire hit_st   = paddr == {`IDX_STATUS, 2'h0};
  wire hit_dat  = paddr == {`IDX_DATA, 2'h0};
  wire hit_seq  = paddr == {`IDX_SEQ_LEN, 2'h0};
  wire mapped   = hit_st | hit_dat | hit_seq;
  wire wr_st    = acc & pwrite & hit_st & pstrb[0];
  wire rd_st    = acc & ~pwrite & hit_st;
  wire wr_dat   = acc & pwrite & hit_dat;
  wire rd_dat   = acc & ~pwrite & hit_dat;
  wire wr_seq   = acc & pwrite & hit_seq & pstrb[0];
  wire rd_tx    = i_read_source_select ==
                  spi_status_and_data_buffers_pkg::rd_from_tx;
  // word access: software sees the buffer low half in the upper lanes
  wire [31:0] wr_val = i_longword_access_select ? pwdata
                       : {16'h0, pwdata[31:16]};

  // ----------------------------------------
  // transmit buffer
  // ----------------------------------------
  logic [31:0] tx_buf_q [STAGES];
  logic [31:0] tx_last_q;
  spi_status_and_data_buffers_pkg::stage_idx_t tx_ptr_q;
  logic        tx_lock_q;
  wire  tx_wrap  = tx_ptr_q == i_frame_count;
  wire  en_rise  = i_enable_write & i_enable_wdata & ~i_function_enable;
  wire  en_again = i_enable_write & i_enable_wdata & i_function_enable;
  wire  tx_take  = wr_dat & ~tx_lock_q;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tx_ptr_q  <= 2'h0;
      tx_lock_q <= 1'b0;
      tx_last_q <= 32'h0;
    end else if (en_rise) begin
      tx_ptr_q  <= 2'h0;
      tx_lock_q <= 1'b0;
    end else if (tx_take) begin
      tx_ptr_q  <= tx_wrap ? 2'h0 : tx_ptr_q + 2'h1;
      tx_lock_q <= tx_wrap;
      tx_last_q <= wr_val;
    end else if (i_tx_empty_event) begin
      tx_lock_q <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : g_tx
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          tx_buf_q[g] <= 32'h0;
        end else if (tx_take && tx_ptr_q == 2'(g)) begin
          tx_buf_q[g] <= wr_val;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_tx_stage_data <= 32'h0;
    end else begin
      o_tx_stage_data <= tx_buf_q[i_tx_stage_sel];
    end
  end
  assign o_tx_has_data = tx_lock_q;

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  logic [31:0] rx_buf_q [STAGES];
  spi_status_and_data_buffers_pkg::stage_idx_t rx_wp_q;
  spi_status_and_data_buffers_pkg::stage_idx_t rx_rp_q;
  logic        rx_full_q;
  wire  rx_frame  = i_xfer_done & ~i_transmit_only_select;
  wire  overrun   = rx_frame & rx_full_q;
  wire  rx_store  = rx_frame & ~rx_full_q;
  wire  rx_read   = rd_dat & ~rd_tx;
  wire  rx_wwrap  = rx_wp_q == i_frame_count;
  wire  rx_rwrap  = rx_rp_q == i_frame_count;
  // full-width frames have no untouched upper bits to copy
  wire [31:0] keep_mask = (i_data_bits >= `FULL_WIDTH) ? 32'h0
                          : ~((32'h1 << i_data_bits) - 32'h1);
  wire [31:0] rx_word = (i_rx_shift_data & ~keep_mask)
                        | (tx_buf_q[rx_wp_q] & keep_mask);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rx_wp_q   <= 2'h0;
      rx_full_q <= 1'b0;
    end else if (rx_store) begin
      rx_wp_q   <= rx_wwrap ? 2'h0 : rx_wp_q + 2'h1;
      rx_full_q <= rx_wwrap;
    end else if (rx_read && rx_rwrap) begin
      rx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rx_rp_q <= 2'h0;
    end else if (en_again) begin
      rx_rp_q <= 2'h0;
    end else if (rx_read) begin
      rx_rp_q <= rx_rwrap ? 2'h0 : rx_rp_q + 2'h1;
    end
  end

  generate
    for (g = 0; g < STAGES; g++) begin : g_rx
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          rx_buf_q[g] <= 32'h0;
        end else if (rx_store && rx_wp_q == 2'(g)) begin
          rx_buf_q[g] <= rx_word;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rx_full_event <= 1'b0;
    end else begin
      o_rx_full_event <= rx_store & rx_wwrap;
    end
  end

  // ----------------------------------------
  // slave transfer tracking
  // ----------------------------------------
  logic [5:0] edge_cnt_q;
  wire slave_fault = ~i_master_select & i_mode_fault_detect_enable
                     & ss_fall & (edge_cnt_q != 6'h0);
  wire master_fault = i_master_select & i_mode_fault_detect_enable
                      & ss_rise;
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !ss_act) begin
      edge_cnt_q <= 6'h0;
    end else if (sclk_rise) begin
      edge_cnt_q <= (edge_cnt_q + 6'h1 >= i_data_bits) ? 6'h0
                    : edge_cnt_q + 6'h1;
    end
  end

  // ----------------------------------------
  // error flags
  // ----------------------------------------
  logic [2:0] flag_q;
  logic [2:0] arm_q;
  wire  [2:0] flag_set = {rx_frame & i_parity_enable & i_parity_bad,
                          slave_fault | master_fault,
                          overrun};
  wire  [2:0] wr_bits = {pwdata[`ST_PARITY_ERROR_FLAG], pwdata[`ST_MODE_FAULT_FLAG],
                         pwdata[`ST_OVR]};
  // a write of 1, or of 0 without a prior read at 1, changes nothing
  wire  [2:0] flag_clr = {3{wr_st}} & arm_q & ~wr_bits;

  generate
    for (g = 0; g < 3; g++) begin : g_flag
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          flag_q[g] <= 1'b0;
          arm_q[g]  <= 1'b0;
        end else begin
          // a set in the clearing cycle wins
          flag_q[g] <= flag_set[g] | (flag_q[g] & ~flag_clr[g]);
          if (rd_st) begin
            arm_q[g] <= flag_q[g];
          end else if (wr_st) begin
            arm_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign o_error_irq = i_error_interrupt_enable & (|flag_q);

  // ----------------------------------------
  // idle flag and sequence control
  // ----------------------------------------
  logic [2:0] seq_len_q;
  wire master_idle = ~i_function_enable | (~tx_lock_q
                     & (i_command_pointer == `CMD_PTR_HOME)
                     & i_seq_idle);
  assign o_transfer_active_flag = i_master_select ? ~master_idle
                                  : i_function_enable;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      seq_len_q <= `SEQ_LEN_RST;
    end else if (wr_seq) begin
      seq_len_q <= pwdata[2:0];
    end
  end
  assign o_sequence_length = seq_len_q;
  assign o_command_select  = i_master_select ? i_command_pointer
                             : `CMD_PTR_HOME;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  wire [31:0] tx_view = tx_lock_q ? 32'h0 : tx_last_q;
  wire [31:0] buf_rd  = rd_tx ? tx_view : rx_buf_q[rx_rp_q];
  wire [31:0] dat_rd  = i_longword_access_select ? buf_rd
                        : {buf_rd[15:0], 16'h0};
  wire [7:0]  st_rd   = {`ST_RSVD_HI, flag_q[2], flag_q[1],
                         o_transfer_active_flag, flag_q[0]};
  assign prdata  = hit_st  ? {24'h0, st_rd}
                 : hit_dat ? dat_rd
                 : hit_seq ? {29'h0, seq_len_q}
                 : 32'h0;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_ovr_armed;
    rd_st && flag_q[0];
  endsequence
  sequence s_ovr_clear;
    wr_st && arm_q[0] && !pwdata[`ST_OVR] && !overrun;
  endsequence

  a_overrun_set: assert property (overrun |=> flag_q[0])
    else $error("overrun not flagged");
  a_ovr_arm: assert property (s_ovr_armed |=> arm_q[0])
    else $error("overrun clear not armed");
  a_overrun_clear: assert property (s_ovr_clear |=> !flag_q[0])
    else $error("overrun not cleared");
  a_flag_keep_one: assert property (
    wr_st && pwdata[0] && flag_q[0] |=> flag_q[0])
    else $error("flag cleared by write of one");
  a_idle_master_off: assert property (
    rd_st && i_master_select && !i_function_enable
    |-> !prdata[`ST_IDLE])
    else $error("idle flag set while disabled");
  a_idle_slave: assert property (rd_st && !i_master_select
    |-> prdata[`ST_IDLE] == i_function_enable)
    else $error("slave idle flag mismatch");
  a_mode_fault_flag_master: assert property (master_fault |=> flag_q[1])
    else $error("master mode fault missed");
  a_mode_fault_flag_slave: assert property (slave_fault |=> flag_q[1])
    else $error("slave mode fault missed");
  a_parity_set: assert property (
    rx_frame && i_parity_enable && i_parity_bad |=> flag_q[2])
    else $error("parity error missed");
  a_rx_hold: assert property (
    overrun |=> $stable(rx_wp_q) && rx_full_q)
    else $error("receive buffer moved on overrun");
  a_tx_locked: assert property (
    wr_dat && tx_lock_q && !en_rise |=> $stable(tx_last_q))
    else $error("write taken while locked");
  a_tx_home: assert property (en_rise |=> tx_ptr_q == 2'h0)
    else $error("tx pointer not homed");
  a_rx_home: assert property (en_again |=> rx_rp_q == 2'h0)
    else $error("rx pointer not homed");

endmodule

// *** spi_far_end.sv ***
/*
  far-side spi party: drives slave select and serial clock for one frame.
  assumes the block samples both pins on its own clock.
*/
`timescale 1ns/1ps
module spi_far_end (
  output logic      o_sclk,
  output logic      o_ss,
  input  wire logic i_pol
);
  logic act_q = 1'b0;
  // inactive level follows polarity, so a polarity flip moves the idle pin
  assign o_ss = act_q ? i_pol : ~i_pol;
  initial o_sclk = 1'b0;
  // clock stands still outside frames; edges below full length end early
  task automatic frame(input int cycles);
    act_q = 1'b1;
    #800;
    repeat (cycles) begin
      o_sclk = 1'b1;
      #400;
      o_sclk = 1'b0;
      #400;
    end
    act_q = 1'b0;
    #800;
  endtask
endmodule

// *** spi_status_and_data_buffers_bench.sv ***
/*
  self-checking bench for the spi status and data buffer block.
  assumes the design, its header and spi_far_end are compiled first.
*/
`timescale 1ns/1ps
`include "spi_status_and_data_buffers_consts.svh"
module spi_status_and_data_buffers_bench;
  // ----------------------------------------
  // signals and hookup
  // ----------------------------------------
  localparam logic [23:0] a_st = {`IDX_STATUS, 2'h0};
  localparam logic [23:0] a_dt = {`IDX_DATA, 2'h0};
  localparam logic [23:0] a_sq = {`IDX_SEQ_LEN, 2'h0};
  typedef struct {logic [1:0] fc; logic [5:0] nb;} row_t;
  row_t rows [4] = '{'{2'h0, 6'h20}, '{2'h1, 6'h08}, '{2'h2, 6'h10}, '{2'h3, 6'h20}};
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic en = 0, enw = 0, envd = 0, ms = 0, txo = 0, mfd = 0, pe = 0, eie = 0, pol = 0, lw = 1;
  logic rds = 0, done = 0, pbad = 0, txe = 0, sidle = 0, txhas, rxfe, irq, idle, sclk, ss, e;
  logic [23:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rxd = 0, txod, r, m;
  logic [31:0] tx [4];
  logic [5:0]  nb = 6'h20;
  logic [1:0]  fc = 0, tsel = 0;
  logic [2:0]  cptr = 0, sql, csel;
  int          err_count = 0, checked = 0, rxf = 0;
  spi_status_and_data_buffers dut (.i_core_clk(clk), .i_rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_function_enable(en),
    .i_enable_write(enw), .i_enable_wdata(envd), .i_master_select(ms),
    .i_transmit_only_select(txo), .i_mode_fault_detect_enable(mfd), .i_parity_enable(pe),
    .i_error_interrupt_enable(eie), .i_slave_select_polarity(pol), .i_frame_count(fc),
    .i_read_source_select(rds), .i_longword_access_select(lw),
    .i_serial_clock_line(sclk), .i_slave_select_pin(ss), .i_xfer_done(done),
    .i_rx_shift_data(rxd), .i_parity_bad(pbad), .i_data_bits(nb), .i_tx_stage_sel(tsel),
    .i_tx_empty_event(txe), .i_seq_idle(sidle), .i_command_pointer(cptr),
    .o_tx_stage_data(txod), .o_tx_has_data(txhas), .o_rx_full_event(rxfe),
    .o_sequence_length(sql), .o_command_select(csel), .o_error_irq(irq),
    .o_transfer_active_flag(idle));
  spi_far_end far (.o_sclk(sclk), .o_ss(ss), .i_pol(pol));
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rxfe === 1'b1) rxf++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [23:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic st(input logic [31:0] exp, input string msg);
    apb(0, a_st, 0);
    chk(r & 32'h0000_00FD, exp, msg);
  endtask
  task automatic xfer(input logic [31:0] d, input logic b);
    @(posedge clk);
    rxd <= d; pbad <= b; done <= 1;
    @(posedge clk);
    done <= 0; pbad <= 0;
  endtask
  task automatic setn(input logic v);
    @(posedge clk);
    enw <= 1; envd <= v;
    @(posedge clk);
    enw <= 0; en <= v;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    st(32'hA0, "status reset");
    apb(0, a_sq, 0);
    chk(r, 0, "seq length reset");
    apb(0, a_dt + 24'h4, 0);
    chk({31'h0, e}, 32'h1, "unmapped");
    $display("test reset done");
    foreach (rows[i]) begin
      fc <= rows[i].fc; nb <= rows[i].nb; rds <= 1;
      setn(0);
      setn(1);
      for (int k = 0; k <= rows[i].fc; k++) begin
        tx[k] = 32'hC3A5_0000 + 32'h1111 * k;
        apb(1, a_dt, tx[k]);
        apb(0, a_dt, 0);
        if (k < rows[i].fc) chk(r, tx[k], "tx readback");
      end
      chk(r, 0, "tx locked read");
      wt(1);
      chk({31'h0, txhas}, 32'h1, "tx locked");
      apb(1, a_dt, 32'hFFFF_0000);
      for (int k = 0; k <= rows[i].fc; k++) begin
        tsel <= k[1:0];
        wt(2);
        chk(txod, tx[k], "tx stage");
      end
      @(posedge clk) txe <= 1;
      @(posedge clk) txe <= 0;
      wt(1);
      chk({31'h0, txhas}, 32'h0, "tx released");
      rds <= 0; rxf = 0;
      m = (rows[i].nb == 6'h20) ? 32'hFFFF_FFFF : (32'h1 << rows[i].nb) - 32'h1;
      for (int k = 0; k <= rows[i].fc; k++) xfer(32'h0F0F_0F0F + k, 0);
      wt(3);
      chk(rxf, 1, "rx full event");
      for (int k = 0; k <= rows[i].fc; k++) begin
        apb(0, a_dt, 0);
        chk(r, (tx[k] & ~m) | ((32'h0F0F_0F0F + k) & m), "rx stage");
      end
      $display("test row %0d done", i);
    end
    // overrun keeps buffer; rewriting enable homes the rx read pointer
    for (int k = 0; k < 4; k++) xfer(32'h100 + k, 0);
    xfer(32'hFFFF_FFFF, 0);
    wt(2);
    st(32'hA1, "overrun set");
    apb(0, a_dt, 0);
    chk(r, 32'h100, "rx first");
    setn(1);
    for (int k = 0; k < 4; k++) begin
      apb(0, a_dt, 0);
      chk(r, 32'h100 + k, "rx kept");
    end
    pe <= 1; eie <= 1;
    xfer(32'h7, 1);
    wt(2);
    st(32'hA9, "parity set");
    chk({31'h0, irq}, 32'h1, "error irq");
    apb(1, a_st, 32'hAD);
    apb(1, a_st, 32'hA0);
    st(32'hA9, "unarmed clear");
    apb(1, a_st, 32'hA0);
    st(32'hA0, "armed clear");
    chk({31'h0, irq}, 32'h0, "irq gone");
    txo <= 1; rxf = 0;
    for (int k = 0; k < 5; k++) xfer(32'h55, 0);
    wt(3);
    st(32'hA0, "tx only no overrun");
    chk(rxf, 0, "tx only no rx");
    txo <= 0; pe <= 0;
    $display("test errors done");
    // idle flag, sequence length and command select
    ms <= 1; sidle <= 1; cptr <= 0;
    wt(4);
    apb(0, a_st, 0);
    chk({31'h0, r[1]}, 32'h0, "master idle");
    cptr <= 3'h5;
    apb(0, a_st, 0);
    chk({31'h0, r[1]}, 32'h1, "master busy");
    chk({31'h0, idle}, 32'h1, "master busy flag");
    chk({29'h0, csel}, 32'h5, "master cmd");
    setn(0);
    apb(0, a_st, 0);
    chk({31'h0, r[1]}, 32'h0, "master disabled");
    setn(1);
    cptr <= 3'h0;
    apb(1, a_sq, 32'h6);
    apb(0, a_sq, 0);
    chk(r, 32'h6, "seq length");
    chk({29'h0, sql}, 32'h6, "seq out");
    ms <= 0; cptr <= 3'h5;
    wt(2);
    chk({29'h0, csel}, 32'h0, "slave cmd");
    apb(0, a_st, 0);
    chk({31'h0, r[1]}, 32'h1, "slave enabled");
    setn(0);
    apb(0, a_st, 0);
    chk({31'h0, r[1]}, 32'h0, "slave disabled");
    setn(1);
    // word access: data rides in the upper half of the bus
    lw <= 0; rds <= 1;
    apb(1, a_dt, 32'h5A5A_0000);
    apb(0, a_dt, 0);
    chk(r, 32'h5A5A_0000, "word readback");
    tsel <= 2'h0;
    wt(2);
    chk(txod, 32'h0000_5A5A, "word stage");
    lw <= 1; rds <= 0;
    $display("test word access done");
    // mode faults from the far end
    ms <= 1; pol <= 1;
    wt(12);
    mfd <= 1;
    wt(4);
    far.frame(0);
    wt(4);
    st(32'hA4, "master fault");
    apb(1, a_st, 32'hA0);
    ms <= 0; pol <= 0; mfd <= 0; nb <= 6'h08;
    wt(12);
    mfd <= 1;
    wt(4);
    far.frame(8);
    wt(6);
    st(32'hA0, "full frame");
    far.frame(3);
    wt(6);
    st(32'hA4, "short frame");
    $display("test faults done");
    // mid-run reset must drop flags and the sequence length
    @(posedge clk) rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    st(32'hA0, "status after reset");
    apb(0, a_sq, 0);
    chk(r, 0, "seq length after reset");
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule
